// ===== logic/pia_top.sv
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pia_top #(
	parameter int PIX_W = 10,
	parameter int DEPTH = pia_pkg::PIA_FIFO_DEPTH
) (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic frame_start, // frame start pulse, same clock
	input wire logic line_start, // line start pulse, same clock
	input wire logic line_odd, // current line is odd
	input wire logic pix_valid, // input pixel valid
	input wire logic [PIX_W-1:0] pix_data, // input pixel
	output logic pix_ready, // input accept
	output logic out_valid, // averaged pixel valid
	input wire logic out_ready, // sink accept
	output logic [PIX_W-1:0] out_data, // averaged pixel
	output logic [15:0] active_stride // stride for this frame
);
	////////////////////////////////////////////////////////////////
	// bus slave
	logic [15:0] stride_q, stride_d;
	logic [5:0] ave_q, ave_d;
	logic ph_wr_q, ph_wr_d;
	logic [11:0] ph_addr_q, ph_addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] act_stride_q, act_stride_d;
	logic busy_q;
	logic addr_ok;
	always_comb begin
		addr_ok = hsel && hready && htrans[1];
		ph_wr_d = addr_ok && hwrite;
		ph_addr_d = addr_ok ? haddr[11:0] : ph_addr_q;
		stride_d = stride_q;
		ave_d = ave_q;
		if (ph_wr_q && ph_addr_q == pia_pkg::PIA_OFF_STRIDE) begin
			// low bits forced to zero in storage
			stride_d = {hwdata[15:5], 5'h00}; // RQ2
		end
		if (ph_wr_q && ph_addr_q == pia_pkg::PIA_OFF_AVE) begin
			ave_d = hwdata[5:0];
		end
		rdata_d = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			case (haddr[11:0])
				pia_pkg::PIA_OFF_STRIDE: rdata_d = {16'h0000, stride_d}; // RQ4
				pia_pkg::PIA_OFF_AVE: rdata_d = {26'h0, ave_d};
				pia_pkg::PIA_OFF_STATUS: rdata_d = {15'h0, busy_q, act_stride_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		// shadow taken only at frame start, so a busy frame keeps its stride
		act_stride_d = frame_start ? stride_d : act_stride_q; // RQ3 RQ1
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stride_q <= pia_pkg::PIA_STRIDE_RST;
			ave_q <= pia_pkg::PIA_AVE_RST;
			ph_wr_q <= 1'b0;
			ph_addr_q <= 12'h000;
			rdata_q <= 32'h0000_0000;
			act_stride_q <= pia_pkg::PIA_STRIDE_RST;
		end else begin
			stride_q <= stride_d;
			ave_q <= ave_d;
			ph_wr_q <= ph_wr_d;
			ph_addr_q <= ph_addr_d;
			rdata_q <= rdata_d;
			act_stride_q <= act_stride_d;
		end
	end
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign active_stride = act_stride_q;
	////////////////////////////////////////////////////////////////
	// averager: four phase slots, one accumulator per colour phase
	logic [1:0] count_f, even_f, odd_f;
	logic [1:0] spacing;
	logic [3:0] group_n;
	pia_pkg::pia_state_t st_q, st_d;
	logic [1:0] ph_q, ph_d;
	logic [PIX_W+2:0] acc_q [4];
	logic [PIX_W+2:0] acc_d [4];
	logic [3:0] num_q [4];
	logic [3:0] num_d [4];
	logic res_v_q, res_v_d;
	logic [PIX_W-1:0] res_q, res_d;
	logic fifo_in_ready;
	logic take;
	logic [PIX_W+2:0] sum;
	assign count_f = ave_q[pia_pkg::PIA_COUNT_LSB +: 2];
	assign even_f = ave_q[pia_pkg::PIA_EVEN_LSB +: 2];
	assign odd_f = ave_q[pia_pkg::PIA_ODD_LSB +: 2];
	assign spacing = line_odd ? odd_f : even_f; // RQ5 RQ6
	assign group_n = 4'h1 << count_f; // RQ7
	// hold input while a result waits for fifo room
	assign pix_ready = st_q == pia_pkg::PIA_ST_LINE && !(res_v_q && !fifo_in_ready);
	assign take = pix_valid && pix_ready;
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		res_v_d = res_v_q && !fifo_in_ready;
		res_d = res_q;
		sum = '0;
		for (int i = 0; i < 4; i++) begin
			acc_d[i] = acc_q[i];
			num_d[i] = num_q[i];
		end
		case (st_q)
			pia_pkg::PIA_ST_IDLE: begin
				if (line_start) begin
					st_d = pia_pkg::PIA_ST_LINE;
				end
			end
			pia_pkg::PIA_ST_LINE: begin
				if (take) begin
					sum = acc_q[ph_q] + {3'h0, pix_data};
					if (num_q[ph_q] + 4'h1 == group_n) begin
						// mean by shift, divisor is a power of two
						res_d = PIX_W'(sum >> count_f); // RQ10
						res_v_d = 1'b1;
						acc_d[ph_q] = '0;
						num_d[ph_q] = 4'h0;
					end else begin
						acc_d[ph_q] = sum;
						num_d[ph_q] = num_q[ph_q] + 4'h1;
					end
					// a line width not divisible by the group leaves partial sums
					ph_d = (ph_q == spacing) ? 2'h0 : ph_q + 2'h1; // RQ9
				end
			end
			default: st_d = pia_pkg::PIA_ST_IDLE;
		endcase
		if (line_start) begin
			ph_d = 2'h0;
			for (int i = 0; i < 4; i++) begin
				acc_d[i] = '0;
				num_d[i] = 4'h0;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= pia_pkg::PIA_ST_IDLE;
			ph_q <= 2'h0;
			res_v_q <= 1'b0;
			res_q <= '0;
			busy_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				acc_q[i] <= '0;
				num_q[i] <= 4'h0;
			end
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			res_v_q <= res_v_d;
			res_q <= res_d;
			busy_q <= st_d == pia_pkg::PIA_ST_LINE;
			for (int i = 0; i < 4; i++) begin
				acc_q[i] <= acc_d[i];
				num_q[i] <= num_d[i];
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// output buffer
	pia_fifo #(.WIDTH(PIX_W), .DEPTH(DEPTH)) u_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(res_v_q),
		.in_ready(fifo_in_ready),
		.in_data(res_q),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);
	////////////////////////////////////////////////////////////////
	// checks
	AST_STRIDE_LOW: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
		stride_q[4:0] == 5'h00) else $error("stride low bits not zero");
	AST_STRIDE_FRAME: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
		!frame_start |=> $stable(act_stride_q)) else $error("stride changed mid frame");
	AST_STRIDE_READ: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
		(hsel && hready && htrans[1] && !hwrite && haddr[11:0] == pia_pkg::PIA_OFF_STRIDE
		&& !ph_wr_q) |=> hrdata[15:0] == stride_q) else $error("stride read wrong");
	AST_STRIDE_WR: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
		(ph_wr_q && ph_addr_q == pia_pkg::PIA_OFF_STRIDE) |=> stride_q[15:5] == $past(hwdata[15:5]))
		else $error("stride write lost");
	AST_ODD_SPACE: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
		(take && line_odd && !line_start && ph_q == odd_f) |=> ph_q == 2'h0)
		else $error("odd spacing wrap wrong");
	AST_EVEN_SPACE: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
		(take && !line_odd && !line_start && ph_q < even_f) |=> ph_q == $past(ph_q) + 2'h1)
		else $error("even spacing step wrong");
	AST_NO_AVG: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
		(take && count_f == 2'h0) |=> res_v_q && res_q == $past(pix_data))
		else $error("bypass mismatch");
	AST_GROUP_OUT: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
		(take && !line_start && num_q[ph_q] + 4'h1 != group_n && !(res_v_q && !fifo_in_ready))
		|=> !res_v_q) else $error("result before group full");
endmodule
`default_nettype wire

// ===== logic/pia_pkg.sv
// Contract
// RQ1 - stride field spaces output line starts
// RQ2 - low five stride bits read as zero
// RQ3 - new stride applies from next frame
// RQ4 - stride read returns latest written value
// RQ5 - odd line spacing is field plus one
// RQ6 - even line spacing is field plus one
// RQ7 - count selects none, 2, 4, 8 average
// RQ8 - software keeps count still during dark subtract
// RQ9 - software makes line width divisible by group
// RQ10 - one mean output per same-colour group
package pia_pkg;
	localparam logic [11:0] PIA_OFF_STRIDE = 12'h000;
	localparam logic [11:0] PIA_OFF_AVE = 12'h004;
	localparam logic [11:0] PIA_OFF_STATUS = 12'h008;
	localparam int PIA_STRIDE_W = 16;
	localparam int PIA_STRIDE_LSB = 5;
	localparam logic [15:0] PIA_STRIDE_RST = 16'h0000;
	localparam logic [5:0] PIA_AVE_RST = 6'h00;
	localparam int PIA_COUNT_LSB = 0;
	localparam int PIA_EVEN_LSB = 2;
	localparam int PIA_ODD_LSB = 4;
	localparam int PIA_FIFO_DEPTH = 32;
	typedef enum logic [1:0] {
		PIA_ST_IDLE = 2'b01,
		PIA_ST_LINE = 2'b10
	} pia_state_t;
endpackage

// ===== logic/pia_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pia_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // not empty
	input wire logic out_ready, // read accept
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic wr, rd;
	always_comb begin
		wr = in_valid && in_ready;
		rd = out_valid && out_ready;
		wp_d = wr ? wp_q + 1'b1 : wp_q;
		rp_d = rd ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
	end
	assign in_ready = cnt_q != DEPTH[AW:0];
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rp_q];
	always_ff @(posedge clk) begin
		if (wr) begin
			mem[wp_q] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

// ===== dv/pia_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pia_mem (
	input wire logic hclk, // clock
	output logic pix_valid, // pixel offered
	output logic [9:0] pix_data, // pixel value
	input wire logic pix_ready, // pixel taken
	input wire logic out_valid, // result offered
	input wire logic [9:0] out_data, // result value
	output logic out_ready, // result taken
	input wire logic stall // hold off results
);
	logic [9:0] got[$];
	initial begin
		pix_valid = 1'b0;
		pix_data = 10'h000;
		out_ready = 1'b0;
	end
	// slow sink: takes a result every other cycle at best
	always @(posedge hclk) begin
		if (out_valid && out_ready)
			got.push_back(out_data);
		out_ready <= !stall && !out_ready;
	end
	task automatic offer(input logic [9:0] v);
		pix_valid <= 1'b1;
		pix_data <= v;
	endtask
	task automatic send(input logic [9:0] v);
		offer(v);
		do @(posedge hclk); while (pix_ready !== 1'b1);
	endtask
	task automatic idle();
		pix_valid <= 1'b0;
		pix_data <= ~pix_data; // released line must not repeat the last value
	endtask
endmodule
`default_nettype wire

// ===== dv/preview_input_averager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module preview_input_averager_tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic frame_start = 1'b0, line_start = 1'b0, line_odd = 1'b0, stall = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, pix_valid, pix_ready, out_valid, out_ready;
	logic [9:0] pix_data, out_data;
	logic [15:0] active_stride;
	logic [9:0] exp[$];
	int err_total = 0, n_checks = 0, n, s;
	always #12.5 hclk = ~hclk;
	pia_top u_pia_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.frame_start(frame_start), .line_start(line_start), .line_odd(line_odd),
		.pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.active_stride(active_stride));
	pia_mem u_pia_mem (.hclk(hclk), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_ready(pix_ready), .out_valid(out_valid), .out_data(out_data),
		.out_ready(out_ready), .stall(stall));
	////////////////////////////////////////////////////////////////////////////////
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic start_line();
		line_start <= 1'b1;
		@(posedge hclk);
		line_start <= 1'b0;
		u_pia_mem.got.delete();
	endtask
	task automatic wait_got(input int k);
		int t;
		t = 0;
		while (u_pia_mem.got.size() < k && t < 500) begin
			@(posedge hclk);
			t++;
		end
		`CHK(u_pia_mem.got.size(), k)
	endtask
	function automatic int px(input int i, input int c);
		return (i * 37 + c * 101) % 1024;
	endfunction
	task report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 20000);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h0, 32'h0);
		`CHK(rd, 32'h0)
		ahb(1'b0, 32'h4, 32'h0);
		`CHK(rd, 32'h0)
		ahb(1'b1, 32'h0, 32'h1234ffff);
		ahb(1'b0, 32'h0, 32'h0);
		`CHK(rd, 32'h0000ffe0)
		`CHK(active_stride, 16'h0000)
		ahb(1'b0, 32'hc, 32'h0);
		`CHK(rd, 32'h0)
		frame_start <= 1'b1;
		@(posedge hclk);
		frame_start <= 1'b0;
		ahb(1'b0, 32'h8, 32'h0);
		`CHK(active_stride, 16'hffe0)
		`CHK(rd, 32'h0000ffe0)
		`CHK(hresp, 1'b0)
		// one line per count code; spacing code equals count to cover all codes
		for (int c = 0; c < 4; c++) begin
			n = 1 << c;
			ahb(1'b1, 32'h4, {26'h0, 2'(c), 2'(c), 2'(c)});
			ahb(1'b0, 32'h4, 32'h0);
			`CHK(rd, {26'h0, 2'(c), 2'(c), 2'(c)})
			line_odd <= c[0];
			start_line();
			if (c == 2) begin
				ahb(1'b1, 32'h0, 32'h40);
				ahb(1'b0, 32'h0, 32'h0);
				`CHK(rd, 32'h40)
				`CHK(active_stride, 16'hffe0)
			end
			exp.delete();
			for (int p = 0; p <= c; p++) begin
				s = 0;
				for (int j = 0; j < n; j++)
					s += px(j * (c + 1) + p, c);
				exp.push_back(10'(s >> c));
			end
			for (int i = 0; i < n * (c + 1); i++)
				u_pia_mem.send(10'(px(i, c)));
			u_pia_mem.idle();
			wait_got(c + 1);
			foreach (exp[i])
				`CHK(u_pia_mem.got[i], exp[i])
		end
		frame_start <= 1'b1;
		@(posedge hclk);
		frame_start <= 1'b0;
		ahb(1'b0, 32'h8, 32'h0);
		`CHK(active_stride, 16'h0040)
		`CHK(rd, 32'h0001_0040)
		// fill the buffer with the sink stalled, then drain it
		ahb(1'b1, 32'h4, 32'h0);
		stall <= 1'b1;
		start_line();
		for (int i = 0; i < 33; i++)
			u_pia_mem.send(10'(i * 3));
		u_pia_mem.offer(10'h063);
		repeat (4) @(posedge hclk);
		`CHK(pix_ready, 1'b0)
		stall <= 1'b0;
		u_pia_mem.send(10'h063);
		u_pia_mem.idle();
		wait_got(34);
		for (int i = 0; i < 33; i++)
			`CHK(u_pia_mem.got[i], 10'(i * 3))
		`CHK(u_pia_mem.got[33], 10'h063)
		@(posedge hclk);
		`CHK(out_valid, 1'b0)
		report_and_stop();
	end
endmodule
`default_nettype wire
